/* File: sim/slpc_far_model.sv */
// Far side model: CPU sleep pulse, wake request levels, one peripheral.
// Assumes every party runs on the system clock.
`timescale 1ns/1ps
`default_nettype none
module slpc_far_model (
	input  wire logic       i_clk,
	input  wire logic       i_resetn,
	input  wire logic       i_go,
	input  wire logic [4:0] i_wake,
	input  wire logic       i_cpu_en,
	input  wire logic       i_per0_en,
	output logic            o_sleep_req,
	output logic [4:0]      o_src,
	output logic [7:0]      o_p0_cnt
);
	// ========
	// CPU: one pulse per sleep instruction
	always_ff @(posedge i_clk) begin
		o_sleep_req <= i_resetn && i_go;
	end
	// Wake levels stay up until the CPU runs again, like a pending interrupt
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			o_src <= 5'h00;
		end else if (i_wake != 5'h00) begin
			o_src <= i_wake;
		end else if (i_cpu_en) begin
			o_src <= 5'h00;
		end
	end
	// Peripheral 0 state only moves while its clock runs
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			o_p0_cnt <= 8'h00;
		end else if (i_per0_en) begin
			o_p0_cnt <= o_p0_cnt + 8'h01;
		end
	end
endmodule
`default_nettype wire

/* File: sim/slpc_top_tb_top.sv */
// Testbench: AXI4-Lite master, mode walk, wake sources, gate model.
// Assumes the far side model and the package are compiled first.
`timescale 1ns/1ps
`default_nettype none
module slpc_top_tb_top;
	import slpc_pkg::*;
	logic        i_sys_clk = 0;
	logic        i_resetn = 0;
	logic [7:0]  awaddr = 0, araddr = 0, p0, snap;
	logic [31:0] wdata = 0, rdata, pr;
	logic        aw = 0, wv = 0, br = 0, ar = 0, rr = 0, go = 0, rtc_en = 1;
	logic [4:0]  wake = 0, src;
	logic        awr, wr, bv, arr, rv, sreq, cpu, nvm, rtc, sys, slp;
	logic [1:0]  bresp, rresp;
	logic [7:0]  per;
	logic [2:0]  m;
	logic [2:0]  modes [5] = '{SLPC_MODE_IDLE, SLPC_MODE_PDOWN, SLPC_MODE_PSAVE, SLPC_MODE_STDBY, SLPC_MODE_ESTDBY};
	int          error_cnt = 0, samples_checked = 0, seed = 32'h5205, s, q[$];

	always #2 i_sys_clk = ~i_sys_clk;

	slpc_top #(.N_PER(8)) dut (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
		.i_axi_awaddr(awaddr), .i_axi_awvalid(aw), .o_axi_awready(awr), .i_axi_wdata(wdata),
		.i_axi_wstrb(4'hF), .i_axi_wvalid(wv), .o_axi_wready(wr), .o_axi_bresp(bresp),
		.o_axi_bvalid(bv), .i_axi_bready(br), .i_axi_araddr(araddr), .i_axi_arvalid(ar),
		.o_axi_arready(arr), .o_axi_rdata(rdata), .o_axi_rresp(rresp), .o_axi_rvalid(rv),
		.i_axi_rready(rr), .i_sleep_req(sreq), .i_irq_any(src[0]), .i_twi_match_irq(src[1]),
		.i_port_async_irq(src[2]), .i_rtc_irq(src[3]), .i_rtc_en(rtc_en), .i_rst_wake(src[4]),
		.o_cpu_clk_en(cpu), .o_nvm_clk_en(nvm), .o_per_clk_en(per), .o_rtc_clk_en(rtc),
		.o_sys_src_en(sys), .o_asleep(slp));
	slpc_far_model far (.i_clk(i_sys_clk), .i_resetn(i_resetn), .i_go(go), .i_wake(wake),
		.i_cpu_en(cpu), .i_per0_en(per[0]), .o_sleep_req(sreq), .o_src(src), .o_p0_cnt(p0));

	// ========
	// Checking and closing
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic print_verdict;
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// Waits at falling edges, where registered outputs have settled
	task automatic wait_hi(ref logic sig, input logic v);
		int n;
		n = 0;
		do begin
			@(negedge i_sys_clk);
			n++;
		end while (sig !== v && n < 200);
		if (sig !== v) begin
			error_cnt++;
			$display("Error at %0t: wait timed out", $time);
			print_verdict();
		end
	endtask

	// ========
	// Bus master: AW and W offered together, each released at its own take
	task automatic wr32(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		bit ta, tw, ka, kw;
		n = 0;
		ta = 1'b0;
		tw = 1'b0;
		@(posedge i_sys_clk);
		awaddr <= a;
		wdata <= d;
		aw <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		while (!(ta && tw) && n < 200) begin
			@(negedge i_sys_clk);
			n++;
			// A ready seen here is sampled with its valid at the coming edge
			ka = !ta && awr;
			kw = !tw && wr;
			@(posedge i_sys_clk);
			if (ka) aw <= 1'b0;
			if (kw) wv <= 1'b0;
			ta = ta || ka;
			tw = tw || kw;
		end
		if (!(ta && tw)) begin
			error_cnt++;
			$display("Error at %0t: write address or data not taken", $time);
			print_verdict();
		end
		wait_hi(bv, 1'b1);
		chk(bresp, er);
		@(posedge i_sys_clk);
		br <= 1'b0;
	endtask
	task automatic rd32(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge i_sys_clk);
		araddr <= a;
		ar <= 1'b1;
		rr <= 1'b1;
		wait_hi(arr, 1'b1);
		@(posedge i_sys_clk);
		ar <= 1'b0;
		wait_hi(rv, 1'b1);
		chk(rdata, e);
		chk(rresp, er);
		@(posedge i_sys_clk);
		rr <= 1'b0;
	endtask
	task automatic pulse;
		@(posedge i_sys_clk);
		go <= 1'b1;
		@(posedge i_sys_clk);
		go <= 1'b0;
	endtask

	// ========
	// Reference model: {cpu, nvm, rtc, sources, peripherals}
	function automatic logic [11:0] gates(input logic [2:0] md, input bit asl);
		int idle, krtc, ksrc;
		idle = !asl || md == SLPC_MODE_IDLE;
		krtc = rtc_en && (idle || md == SLPC_MODE_PSAVE || md == SLPC_MODE_ESTDBY);
		ksrc = idle || md == SLPC_MODE_STDBY || md == SLPC_MODE_ESTDBY;
		return {!asl, !asl, krtc[0], ksrc[0], idle ? ~pr[7:0] : 8'h00};
	endfunction
	// Wake source index: 0 irq, 1 twi, 2 port, 3 rtc, 4 reset
	function automatic bit ok(input logic [2:0] md, input int k);
		if (k == 4) return 1;
		if (md == SLPC_MODE_IDLE) return k == 0;
		if (k == 3) return rtc_en && (md == SLPC_MODE_PSAVE || md == SLPC_MODE_ESTDBY);
		return k == 1 || k == 2;
	endfunction

	// ========
	// Main sequence
	initial begin
		repeat (5) @(posedge i_sys_clk);
		@(negedge i_sys_clk);
		chk({cpu, nvm, rtc, sys, per, slp}, 13'h1BFE);
		@(posedge i_sys_clk);
		i_resetn <= 1'b1;
		rd32(SLPC_OFF_CAUSE, 32'h0, SLPC_RESP_OKAY);
		// Peripheral 0 kept stopped so that its count must stay frozen
		pr = $random(seed) | 32'h1;
		wr32(SLPC_OFF_PR, pr, SLPC_RESP_OKAY);
		rd32(SLPC_OFF_PR, pr & 32'hFF, SLPC_RESP_OKAY);
		wr32(SLPC_OFF_STAT, pr, SLPC_RESP_SLVERR);
		rd32(8'h10, 32'h0, SLPC_RESP_SLVERR);
		snap = p0;
		pulse();
		repeat (4) @(negedge i_sys_clk);
		chk(slp, 1'b0);
		chk(p0, snap);
		// Enabled but illegal mode code must not start sleep
		wr32(SLPC_OFF_CTRL, 32'h3, SLPC_RESP_OKAY);
		rd32(SLPC_OFF_CTRL, 32'h3, SLPC_RESP_OKAY);
		pulse();
		repeat (4) @(negedge i_sys_clk);
		chk(slp, 1'b0);
		for (int i = 0; i < 5; i++) begin
			m = modes[i];
			wr32(SLPC_OFF_CTRL, {28'h0, m, 1'b1}, SLPC_RESP_OKAY);
			rtc_en <= 1'($random(seed));
			pulse();
			wait_hi(slp, 1'b1);
			chk({cpu, nvm, rtc, sys, per}, gates(m, 1));
			snap = p0;
			rd32(SLPC_OFF_STAT, {28'h0, m, 1'b1}, SLPC_RESP_OKAY);
			if (i != 0) begin
				@(posedge i_sys_clk);
				wake <= 5'h01;
				@(posedge i_sys_clk);
				wake <= 5'h00;
				repeat (5) @(negedge i_sys_clk);
				chk(slp, 1'b1);
				chk(p0, snap);
			end
			q = {};
			for (int k = 0; k < 5; k++) if (ok(m, k)) q.push_back(k);
			s = q[{$random(seed)} % q.size()];
			@(posedge i_sys_clk);
			wake <= 5'h01 << s;
			@(posedge i_sys_clk);
			wake <= 5'h00;
			wait_hi(cpu, 1'b1);
			chk({cpu, nvm, rtc, sys, per}, gates(m, 0));
			chk(slp, 1'b0);
			// Only the chosen source qualified, so only its cause is recorded
			rd32(SLPC_OFF_CAUSE, 32'h1 << s, SLPC_RESP_OKAY);
			wr32(SLPC_OFF_CAUSE, 32'h1F, SLPC_RESP_OKAY);
		end
		print_verdict();
	end
	// Hang guard
	initial begin
		repeat (100000) @(posedge i_sys_clk);
		error_cnt++;
		$display("Error at %0t: run too long", $time);
		print_verdict();
	end
endmodule
`default_nettype wire

/* File: src/slpc_clk_gate.sv */
// Clock gate decoder: registered clock enables for CPU, memory,
// peripherals, real-time counter and system clock sources.
// Assumes each enable drives a glitch-free gate in its clock domain.
`timescale 1ns/1ps
`default_nettype none
module slpc_clk_gate #(
	parameter int N_PER = 8
) (
	input  wire logic                 i_sys_clk,
	input  wire logic                 i_resetn,
	input  wire slpc_pkg::slpc_state_t i_state,
	input  wire logic [2:0]           i_mode,
	input  wire logic [N_PER-1:0]     i_per_stop,
	input  wire logic                 i_rtc_en,
	output logic                      o_cpu_clk_en,
	output logic                      o_nvm_clk_en,
	output logic [N_PER-1:0]          o_per_clk_en,
	output logic                      o_rtc_clk_en,
	output logic                      o_sys_src_en
);
	import slpc_pkg::*;

	// ====================================================================
	// Enables follow the sequencer state one cycle later
	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			o_cpu_clk_en <= SLPC_CLK_ON_RST;
			o_nvm_clk_en <= SLPC_CLK_ON_RST;
			o_per_clk_en <= {N_PER{SLPC_CLK_ON_RST}};
			o_rtc_clk_en <= SLPC_RTC_ON_RST;
			o_sys_src_en <= SLPC_CLK_ON_RST;
		end else begin
			o_per_clk_en <= '0;
			o_rtc_clk_en <= 1'b0;
			o_sys_src_en <= 1'b0;
			o_cpu_clk_en <= 1'b0;
			o_nvm_clk_en <= 1'b0;
			unique case (i_state)
				SLPC_ST_ACTIVE, SLPC_ST_WAKE: begin
					// CPU stays held during the restore cycle
					o_cpu_clk_en <= (i_state == SLPC_ST_ACTIVE);
					o_nvm_clk_en <= 1'b1;
					o_per_clk_en <= ~i_per_stop;
					o_rtc_clk_en <= i_rtc_en;
					o_sys_src_en <= 1'b1;
				end
				SLPC_ST_ASLEEP: begin
					unique case (i_mode)
						SLPC_MODE_IDLE: begin
							o_per_clk_en <= ~i_per_stop;
							o_rtc_clk_en <= i_rtc_en;
							o_sys_src_en <= 1'b1;
						end
						SLPC_MODE_PSAVE: begin
							o_rtc_clk_en <= i_rtc_en;
						end
						SLPC_MODE_STDBY: begin
							o_sys_src_en <= 1'b1;
						end
						SLPC_MODE_ESTDBY: begin
							o_sys_src_en <= 1'b1;
							o_rtc_clk_en <= i_rtc_en;
						end
						default: begin
							o_sys_src_en <= 1'b0; // Power-down: everything stopped
						end
					endcase
				end
			endcase
		end
	end
endmodule
`default_nettype wire

/* File: src/slpc_pkg.sv */
// Sleep controller package: register map, field positions, mode codes,
// reset values, sequencer states and shared helper functions.
// Assumes a 32-bit AXI4-Lite register port addressed in bytes.
package slpc_pkg;
	// ====================================================================
	// Register map (byte offsets, one aligned word each)
	localparam int         SLPC_ADDR_W   = 8;
	localparam logic [7:0] SLPC_OFF_CTRL  = 8'h00;
	localparam logic [7:0] SLPC_OFF_PR    = 8'h04;
	localparam logic [7:0] SLPC_OFF_STAT  = 8'h08;
	localparam logic [7:0] SLPC_OFF_CAUSE = 8'h0C;

	// ====================================================================
	// Field positions
	localparam int SLPC_CTRL_EN       = 0;
	localparam int SLPC_CTRL_MODE_LSB = 1;
	localparam int SLPC_MODE_W        = 3;
	localparam int SLPC_STAT_ASLEEP   = 0;
	localparam int SLPC_STAT_MODE_LSB = 1;
	localparam int SLPC_STAT_WAKING   = 4;
	localparam int SLPC_CAUSE_IRQ     = 0;
	localparam int SLPC_CAUSE_TWI     = 1;
	localparam int SLPC_CAUSE_PORT    = 2;
	localparam int SLPC_CAUSE_RTC     = 3;
	localparam int SLPC_CAUSE_RST     = 4;
	localparam int SLPC_CAUSE_W       = 5;

	// ====================================================================
	// Sleep mode codes
	localparam logic [2:0] SLPC_MODE_IDLE   = 3'h0;
	localparam logic [2:0] SLPC_MODE_PDOWN  = 3'h2;
	localparam logic [2:0] SLPC_MODE_PSAVE  = 3'h3;
	localparam logic [2:0] SLPC_MODE_STDBY  = 3'h6;
	localparam logic [2:0] SLPC_MODE_ESTDBY = 3'h7;

	// ====================================================================
	// Reset values and bus responses
	localparam logic [31:0] SLPC_CTRL_RST   = 32'h0000_0000;
	localparam logic [31:0] SLPC_PR_RST     = 32'h0000_0000;
	localparam logic [4:0]  SLPC_CAUSE_INIT = 5'h00;
	localparam logic        SLPC_CLK_ON_RST = 1'b1;
	localparam logic        SLPC_RTC_ON_RST = 1'b0;
	localparam logic [1:0]  SLPC_RESP_OKAY  = 2'h0;
	localparam logic [1:0]  SLPC_RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {SLPC_ST_ACTIVE, SLPC_ST_ASLEEP, SLPC_ST_WAKE} slpc_state_t;

	// True for the five selectable sleep modes
	function automatic logic slpc_mode_legal(input logic [2:0] mode);
		return mode inside {SLPC_MODE_IDLE, SLPC_MODE_PDOWN, SLPC_MODE_PSAVE, SLPC_MODE_STDBY, SLPC_MODE_ESTDBY};
	endfunction

	// Byte-lane merge of a write into a stored word
	function automatic logic [31:0] slpc_strb_merge(input logic [31:0] old_v, input logic [31:0] new_v,
			input logic [3:0] strb);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return res;
	endfunction
endpackage

/* File: src/slpc_top.sv */
// Sleep and clock gating controller top: AXI4-Lite registers, sleep
// sequencer, wake qualification and clock enable outputs.
// Assumes the CPU pulses i_sleep_req when it executes its sleep instruction
// and that all inputs are synchronous to i_sys_clk.
`timescale 1ns/1ps
`default_nettype none
module slpc_top #(
	parameter int N_PER = 8
) (
	input  wire logic                           i_sys_clk,
	input  wire logic                           i_resetn,
	input  wire logic [slpc_pkg::SLPC_ADDR_W-1:0] i_axi_awaddr,
	input  wire logic                           i_axi_awvalid,
	output logic                                o_axi_awready,
	input  wire logic [31:0]                    i_axi_wdata,
	input  wire logic [3:0]                     i_axi_wstrb,
	input  wire logic                           i_axi_wvalid,
	output logic                                o_axi_wready,
	output logic [1:0]                          o_axi_bresp,
	output logic                                o_axi_bvalid,
	input  wire logic                           i_axi_bready,
	input  wire logic [slpc_pkg::SLPC_ADDR_W-1:0] i_axi_araddr,
	input  wire logic                           i_axi_arvalid,
	output logic                                o_axi_arready,
	output logic [31:0]                         o_axi_rdata,
	output logic [1:0]                          o_axi_rresp,
	output logic                                o_axi_rvalid,
	input  wire logic                           i_axi_rready,
	input  wire logic                           i_sleep_req,
	input  wire logic                           i_irq_any,
	input  wire logic                           i_twi_match_irq,
	input  wire logic                           i_port_async_irq,
	input  wire logic                           i_rtc_irq,
	input  wire logic                           i_rtc_en,
	input  wire logic                           i_rst_wake,
	output logic                                o_cpu_clk_en,
	output logic                                o_nvm_clk_en,
	output logic [N_PER-1:0]                    o_per_clk_en,
	output logic                                o_rtc_clk_en,
	output logic                                o_sys_src_en,
	output logic                                o_asleep
);
	import slpc_pkg::*;

	// ====================================================================
	// Elaboration check
	// Peripheral stop mask must fit one register word
	if (N_PER < 1 || N_PER > 32) begin : g_bad_nper
		$error("N_PER must be between 1 and 32");
	end

	// ====================================================================
	// Declarations
	slpc_state_t       state_r;
	logic [2:0]        mode_r;
	logic              ctrl_en_r;
	logic [2:0]        ctrl_mode_r;
	logic [N_PER-1:0]  pr_r;
	logic [4:0]        cause_r;
	logic              aw_got_r;
	logic              w_got_r;
	logic [SLPC_ADDR_W-1:0] awaddr_r;
	logic [31:0]       wdata_r;
	logic [3:0]        wstrb_r;
	logic              wr_do;
	logic              sleep_take;
	logic              wake;
	logic [4:0]        wake_cause;
	logic [31:0]       ctrl_word;
	logic [31:0]       pr_word;
	logic [31:0]       ctrl_nxt;
	logic [31:0]       pr_nxt;
	logic [31:0]       rd_word;
	logic              rd_hit;

	// ====================================================================
	// Register views
	always_comb begin
		ctrl_word = '0;
		ctrl_word[SLPC_CTRL_EN] = ctrl_en_r;
		ctrl_word[SLPC_CTRL_MODE_LSB +: SLPC_MODE_W] = ctrl_mode_r;
		pr_word = '0;
		pr_word[N_PER-1:0] = pr_r;
		ctrl_nxt = slpc_strb_merge(ctrl_word, wdata_r, wstrb_r);
		pr_nxt = slpc_strb_merge(pr_word, wdata_r, wstrb_r);
	end

	// ====================================================================
	// Write channel: address and data taken in either order
	assign wr_do = aw_got_r && w_got_r && !o_axi_bvalid;

	// Write address ready drops while a write is held or answered
	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			o_axi_awready <= 1'b0;
			aw_got_r <= 1'b0;
			awaddr_r <= '0;
		end else if (i_axi_awvalid && o_axi_awready) begin
			o_axi_awready <= 1'b0;
			aw_got_r <= 1'b1;
			awaddr_r <= i_axi_awaddr;
		end else if (wr_do) begin
			aw_got_r <= 1'b0;
		end else if (!aw_got_r && !o_axi_bvalid) begin
			o_axi_awready <= 1'b1;
		end
	end

	// Write data capture
	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			o_axi_wready <= 1'b0;
			w_got_r <= 1'b0;
			wdata_r <= '0;
			wstrb_r <= '0;
		end else if (i_axi_wvalid && o_axi_wready) begin
			o_axi_wready <= 1'b0;
			w_got_r <= 1'b1;
			wdata_r <= i_axi_wdata;
			wstrb_r <= i_axi_wstrb;
		end else if (wr_do) begin
			w_got_r <= 1'b0;
		end else if (!w_got_r && !o_axi_bvalid) begin
			o_axi_wready <= 1'b1;
		end
	end

	// Write response; unmapped or read-only offsets answer SLVERR
	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			o_axi_bvalid <= 1'b0;
			o_axi_bresp <= SLPC_RESP_OKAY;
		end else if (wr_do) begin
			o_axi_bvalid <= 1'b1;
			if (awaddr_r[7:2] == SLPC_OFF_CTRL[7:2] || awaddr_r[7:2] == SLPC_OFF_PR[7:2] ||
					awaddr_r[7:2] == SLPC_OFF_CAUSE[7:2]) begin
				o_axi_bresp <= SLPC_RESP_OKAY;
			end else begin
				o_axi_bresp <= SLPC_RESP_SLVERR;
			end
		end else if (i_axi_bready) begin
			o_axi_bvalid <= 1'b0;
		end
	end

	// ====================================================================
	// Software registers
	// Mode and enable are only sampled when the CPU asks to sleep
	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			ctrl_en_r <= SLPC_CTRL_RST[SLPC_CTRL_EN];
			ctrl_mode_r <= SLPC_CTRL_RST[SLPC_CTRL_MODE_LSB +: SLPC_MODE_W];
		end else if (wr_do && awaddr_r[7:2] == SLPC_OFF_CTRL[7:2]) begin
			ctrl_en_r <= ctrl_nxt[SLPC_CTRL_EN];
			ctrl_mode_r <= ctrl_nxt[SLPC_CTRL_MODE_LSB +: SLPC_MODE_W];
		end
	end

	// Per-peripheral clock stop mask, one bit per peripheral
	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			pr_r <= SLPC_PR_RST[N_PER-1:0];
		end else if (wr_do && awaddr_r[7:2] == SLPC_OFF_PR[7:2]) begin
			pr_r <= pr_nxt[N_PER-1:0];
		end
	end

	// Sticky wake causes, write one to clear; a new cause wins the clear
	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			cause_r <= SLPC_CAUSE_INIT;
		end else begin
			cause_r <= (cause_r & ~((wr_do && awaddr_r[7:2] == SLPC_OFF_CAUSE[7:2] && wstrb_r[0]) ?
				wdata_r[4:0] : 5'h00)) | ((state_r == SLPC_ST_ASLEEP && wake) ? wake_cause : 5'h00);
		end
	end

	// ====================================================================
	// Read channel: answer in the cycle after the address is taken
	always_comb begin
		rd_word = '0;
		rd_hit = 1'b1;
		unique case (i_axi_araddr[7:2])
			SLPC_OFF_CTRL[7:2]: begin
				rd_word = ctrl_word;
			end
			SLPC_OFF_PR[7:2]: begin
				rd_word = pr_word;
			end
			SLPC_OFF_STAT[7:2]: begin
				rd_word[SLPC_STAT_ASLEEP] = (state_r == SLPC_ST_ASLEEP);
				rd_word[SLPC_STAT_MODE_LSB +: SLPC_MODE_W] = mode_r;
				rd_word[SLPC_STAT_WAKING] = (state_r == SLPC_ST_WAKE);
			end
			SLPC_OFF_CAUSE[7:2]: begin
				rd_word[SLPC_CAUSE_W-1:0] = cause_r;
			end
			default: begin
				rd_hit = 1'b0;
			end
		endcase
	end

	// Read address ready returns once the data beat is accepted
	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			o_axi_arready <= 1'b0;
			o_axi_rvalid <= 1'b0;
			o_axi_rdata <= '0;
			o_axi_rresp <= SLPC_RESP_OKAY;
		end else if (i_axi_arvalid && o_axi_arready) begin
			o_axi_arready <= 1'b0;
			o_axi_rvalid <= 1'b1;
			o_axi_rdata <= rd_word;
			o_axi_rresp <= rd_hit ? SLPC_RESP_OKAY : SLPC_RESP_SLVERR;
		end else if (o_axi_rvalid) begin
			if (i_axi_rready) begin
				o_axi_rvalid <= 1'b0;
			end
		end else begin
			o_axi_arready <= 1'b1;
		end
	end

	// ====================================================================
	// Sleep sequencer
	// Only a legal mode with sleep enabled is entered on the CPU's request
	assign sleep_take = i_sleep_req && state_r == SLPC_ST_ACTIVE && ctrl_en_r &&
		slpc_mode_legal(ctrl_mode_r);

	slpc_wake_qual u_wake (
		.i_mode           (mode_r),
		.i_irq_any        (i_irq_any),
		.i_twi_match_irq  (i_twi_match_irq),
		.i_port_async_irq (i_port_async_irq),
		.i_rtc_irq        (i_rtc_irq),
		.i_rtc_en         (i_rtc_en),
		.i_rst_wake       (i_rst_wake),
		.o_wake           (wake),
		.o_cause          (wake_cause)
	);

	// One restore cycle lets the gates reopen before the CPU clock does
	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			state_r <= SLPC_ST_ACTIVE;
			mode_r <= SLPC_MODE_IDLE;
		end else begin
			unique case (state_r)
				SLPC_ST_ACTIVE: begin
					if (sleep_take) begin
						state_r <= SLPC_ST_ASLEEP;
						mode_r <= ctrl_mode_r;
					end
				end
				SLPC_ST_ASLEEP: begin
					if (wake) begin
						state_r <= SLPC_ST_WAKE;
					end
				end
				SLPC_ST_WAKE: begin
					state_r <= SLPC_ST_ACTIVE;
				end
			endcase
		end
	end

	// Sleep indication for the outside world
	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			o_asleep <= 1'b0;
		end else begin
			o_asleep <= (state_r == SLPC_ST_ASLEEP);
		end
	end

	// ====================================================================
	// Clock enables
	slpc_clk_gate #(
		.N_PER (N_PER)
	) u_gate (
		.i_sys_clk    (i_sys_clk),
		.i_resetn     (i_resetn),
		.i_state      (state_r),
		.i_mode       (mode_r),
		.i_per_stop   (pr_r),
		.i_rtc_en     (i_rtc_en),
		.o_cpu_clk_en (o_cpu_clk_en),
		.o_nvm_clk_en (o_nvm_clk_en),
		.o_per_clk_en (o_per_clk_en),
		.o_rtc_clk_en (o_rtc_clk_en),
		.o_sys_src_en (o_sys_src_en)
	);

	// ====================================================================
	// Assertions
	sleep_entry_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		sleep_take |=> state_r == SLPC_ST_ASLEEP && mode_r == $past(ctrl_mode_r))
		else $error("requested sleep not entered");
	sleep_refuse_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		state_r == SLPC_ST_ACTIVE && !(i_sleep_req && ctrl_en_r && slpc_mode_legal(ctrl_mode_r))
		|=> state_r == SLPC_ST_ACTIVE)
		else $error("sleep entered without a valid request");

	idle_gate_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		state_r == SLPC_ST_ASLEEP && mode_r == SLPC_MODE_IDLE
		|=> !o_cpu_clk_en && !o_nvm_clk_en && o_sys_src_en && o_per_clk_en == ~$past(pr_r))
		else $error("idle clock gating wrong");
	active_stop_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		state_r == SLPC_ST_ACTIVE ##1 state_r == SLPC_ST_ACTIVE
		|=> o_cpu_clk_en && o_per_clk_en == ~$past(pr_r))
		else $error("peripheral stop not applied in active");

	pdown_gate_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		state_r == SLPC_ST_ASLEEP && mode_r == SLPC_MODE_PDOWN
		|=> !o_cpu_clk_en && !o_nvm_clk_en && o_per_clk_en == '0 && !o_rtc_clk_en && !o_sys_src_en)
		else $error("power-down left a clock running");
	pdown_ignore_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		state_r == SLPC_ST_ASLEEP && mode_r == SLPC_MODE_PDOWN && !i_twi_match_irq &&
		!i_port_async_irq && !i_rst_wake |=> state_r == SLPC_ST_ASLEEP)
		else $error("power-down woke on a disallowed source");

	idle_wake_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		state_r == SLPC_ST_ASLEEP && mode_r == SLPC_MODE_IDLE && i_irq_any |=> state_r == SLPC_ST_WAKE)
		else $error("idle did not wake on interrupt");
	reset_wake_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		state_r == SLPC_ST_ASLEEP && i_rst_wake |=> state_r == SLPC_ST_WAKE ##1 state_r == SLPC_ST_ACTIVE)
		else $error("enabled reset did not wake");

	psave_rtc_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		state_r == SLPC_ST_ASLEEP && mode_r == SLPC_MODE_PSAVE
		|=> o_rtc_clk_en == $past(i_rtc_en) && !o_sys_src_en && o_per_clk_en == '0)
		else $error("power-save clocks wrong");
	stdby_src_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		state_r == SLPC_ST_ASLEEP && mode_r == SLPC_MODE_STDBY
		|=> o_sys_src_en && !o_cpu_clk_en && !o_rtc_clk_en && o_per_clk_en == '0)
		else $error("standby clocks wrong");

	estdby_clk_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		state_r == SLPC_ST_ASLEEP && mode_r == SLPC_MODE_ESTDBY
		|=> o_sys_src_en && o_rtc_clk_en == $past(i_rtc_en) && !o_cpu_clk_en)
		else $error("extended standby clocks wrong");
	wake_order_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		state_r == SLPC_ST_WAKE |=> !o_cpu_clk_en && o_nvm_clk_en && o_sys_src_en ##1 o_cpu_clk_en)
		else $error("CPU resumed before clocks restored");

	stop_freeze_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		pr_r[0] && $past(pr_r[0]) && state_r != SLPC_ST_WAKE |-> !o_per_clk_en[0])
		else $error("stopped peripheral still clocked");
endmodule
`default_nettype wire

/* File: src/slpc_wake_qual.sv */
// Wake qualifier: picks which wake requests count in the current mode.
// Assumes interrupt requests arrive already enabled by their owners.
`timescale 1ns/1ps
`default_nettype none
module slpc_wake_qual (
	input  wire logic [2:0] i_mode,
	input  wire logic       i_irq_any,
	input  wire logic       i_twi_match_irq,
	input  wire logic       i_port_async_irq,
	input  wire logic       i_rtc_irq,
	input  wire logic       i_rtc_en,
	input  wire logic       i_rst_wake,
	output logic            o_wake,
	output logic [4:0]      o_cause
);
	import slpc_pkg::*;

	// ====================================================================
	// Per-mode wake filter; an enabled reset wakes from every mode
	always_comb begin
		o_cause = '0;
		o_cause[SLPC_CAUSE_RST] = i_rst_wake;
		unique case (i_mode)
			SLPC_MODE_IDLE: begin
				o_cause[SLPC_CAUSE_IRQ] = i_irq_any;
			end
			SLPC_MODE_PDOWN, SLPC_MODE_STDBY: begin
				o_cause[SLPC_CAUSE_TWI]  = i_twi_match_irq;
				o_cause[SLPC_CAUSE_PORT] = i_port_async_irq;
			end
			SLPC_MODE_PSAVE, SLPC_MODE_ESTDBY: begin
				o_cause[SLPC_CAUSE_TWI]  = i_twi_match_irq;
				o_cause[SLPC_CAUSE_PORT] = i_port_async_irq;
				o_cause[SLPC_CAUSE_RTC]  = i_rtc_irq & i_rtc_en;
			end
			default: begin
				o_cause[SLPC_CAUSE_IRQ] = 1'b0; // Unused codes never reach sleep
			end
		endcase
		o_wake = |o_cause;
	end
endmodule
`default_nettype wire
